// *** hdl/cfg_port_defines.vh ***
/*
 Constants for the parallel configuration port readback block.
 Assumes inclusion by bare name from the design files.
*/
// How it works
// - Data pins are inputs while select is 0, driven while select is 1 with chip select asserted and pins not in user I/O.
// - Changing direction while chip select is asserted enters abort.
// - Chip select and direction pass two system clock flops; direction is checked every system clock.
// - Preamble: dummy, width sync, width detect, dummy, then sync word.
// - Header 2800E001 requests one status register word.
// - Exactly one status word is driven in the following read cycle.
// - Header 30008001 then command 0000000D desynchronizes the port.
// - Other readable registers answer by header address and count.
// - Frame data readout works whether user design runs or is shut down.
// - User block RAM access is denied while readback touches it.
// - Capture readback includes logic-block and io-block register state.
// - Capture trigger or global capture command stores user registers.
// - Without persist, data pins return to user I/O after configuration.
// - Before sync word all data is ignored; then await a valid header.
`ifndef CFG_PORT_DEFINES_VH
`define CFG_PORT_DEFINES_VH
`define SYNC_WORD        32'hAA99_5566
`define NO_OP_WORD       32'h2000_0000
`define DESYNCHRONIZE_CMD 32'h0000_000D
`define GLOBAL_CAPTURE_CMD 32'h0000_000C
`define HDR_TYPE_LSB     29
`define HDR_TYPE1        3'h1
`define HDR_TYPE2        3'h2
`define HDR_OP_LSB       27
`define HDR_OP_READ      2'h1
`define HDR_OP_WRITE     2'h2
`define HDR_ADDR_LSB     13
`define HDR_CNT1_W       11
`define REG_CMD          5'h04
`define REG_FRAME_OUT    5'h03
`define REG_STAT         5'h07
`define REG_COR0         5'h09
`define REG_IDCODE       5'h0C
`define FLUSH_WORDS      2'h2
`endif

// *** hdl/pin_sync.v ***
/*
 Two flip-flop synchroniser with edge detect on the synced level.
 Assumes an asynchronous input and the system clock.
*/
`timescale 1ns/10ps
module pin_sync #(
   parameter WIDTH = 1
) (
   input  wire             clock,
   input  wire             sys_rst,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] level,
   output wire [WIDTH-1:0] rise
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;
   reg [WIDTH-1:0] prev_q;

   always @(posedge clock) begin
      if (sys_rst) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
         prev_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise  = sync_q & ~prev_q;
endmodule // pin_sync

// *** hdl/config_port_readback.v ***
/*
 Device-side configuration port: packet processor for register
 readback, desynchronize_command, capture and abort on direction change.
 Assumes config_clock, chip select and direction come from the host
 and are far slower than clock; status and frame data come from the
 surrounding configuration logic.
*/
`timescale 1ns/10ps
`include "cfg_port_defines.vh"
module config_port_readback #(
   parameter DW = 32
) (
   input  wire          clock,
   input  wire          sys_rst,
   input  wire          config_clock,
   input  wire          chip_select_n,
   input  wire          read_write_select_n,
   input  wire [DW-1:0] data_in,
   output reg  [DW-1:0] data_out,
   output reg           data_oe,
   input  wire          persist,
   input  wire          config_done,
   input  wire          design_shutdown,
   input  wire [DW-1:0] status_word,
   input  wire [DW-1:0] cor0_word,
   input  wire [DW-1:0] idcode_word,
   input  wire [DW-1:0] frame_word,
   input  wire          capture_trigger,
   output reg           frame_word_pop,
   output reg           capture_strobe,
   output reg           capture_with_regs,
   output reg           bram_user_deny,
   output reg           pins_user_io,
   output reg           synced,
   output reg           abort
);
   localparam ST_IDLE  = 4'b0001;
   localparam ST_HDR   = 4'b0010;
   localparam ST_WDATA = 4'b0100;
   localparam ST_RDATA = 4'b1000;

   wire [2:0]    lvl;
   wire [2:0]    rse;
   reg  [DW-1:0] din_m_q;
   reg  [DW-1:0] din_q;
   reg           rw_prev_q;
   reg  [3:0]    state_q;
   reg  [4:0]    addr_q;
   reg  [26:0]   count_q;
   reg  [1:0]    op_q;
   reg  [1:0]    flush_q;

   pin_sync #(.WIDTH(3)) u_sync (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .async_in ({capture_trigger, read_write_select_n, config_clock}),
      .level    (lvl),
      .rise     (rse)
   );

   reg  cs_m_q;
   reg  chip_select_sync;
   wire cfg_clk_rise = rse[0];
   wire rw_sel       = lvl[1];
   wire cs_act       = ~chip_select_sync;

   // Data and chip select pass two flops before use
   always @(posedge clock) begin
      if (sys_rst) begin
         din_m_q          <= {DW{1'b0}};
         din_q            <= {DW{1'b0}};
         cs_m_q           <= 1'b1;
         chip_select_sync <= 1'b1;
      end else begin
         din_m_q          <= data_in;
         din_q            <= din_m_q;
         cs_m_q           <= chip_select_n;
         chip_select_sync <= cs_m_q;
      end
   end

   // Read mux by register address
   function [DW-1:0] reg_read;
      input [4:0] a;
      begin
         if (a == `REG_STAT)
            reg_read = status_word;
         else if (a == `REG_COR0)
            reg_read = cor0_word;
         else if (a == `REG_IDCODE)
            reg_read = idcode_word;
         else if (a == `REG_FRAME_OUT)
            reg_read = frame_word;
         else
            reg_read = {DW{1'b0}};
      end
   endfunction

   // Registers that answer a read
   function readable;
      input [4:0] a;
      begin
         readable = (a == `REG_STAT) || (a == `REG_COR0) ||
                    (a == `REG_IDCODE) || (a == `REG_FRAME_OUT);
      end
   endfunction

   wire word_in  = cfg_clk_rise & cs_act & ~rw_sel;
   wire word_out = cfg_clk_rise & cs_act & rw_sel;
   wire [2:0] htype = din_q[31:`HDR_TYPE_LSB];
   wire [1:0] hop   = din_q[28:`HDR_OP_LSB];

   always @(posedge clock) begin
      if (sys_rst) begin
         state_q           <= ST_IDLE;
         synced            <= 1'b0;
         abort             <= 1'b0;
         rw_prev_q         <= 1'b0;
         addr_q            <= 5'h00;
         count_q           <= 27'h000_0000;
         op_q              <= 2'h0;
         flush_q           <= 2'h0;
         data_out          <= {DW{1'b0}};
         data_oe           <= 1'b0;
         frame_word_pop    <= 1'b0;
         capture_strobe    <= 1'b0;
         capture_with_regs <= 1'b0;
         bram_user_deny    <= 1'b0;
         pins_user_io      <= 1'b0;
      end else begin
         frame_word_pop <= 1'b0;
         capture_strobe <= rse[2];
         rw_prev_q      <= rw_sel;
         pins_user_io   <= config_done & ~persist;
         data_oe <= rw_sel & cs_act & ~pins_user_io;
         bram_user_deny <= (state_q == ST_RDATA) &&
                           (addr_q == `REG_FRAME_OUT);
         // Direction flip while selected aborts
         if (cs_act && (rw_sel != rw_prev_q)) begin
            abort   <= 1'b1;
            synced  <= 1'b0;
            state_q <= ST_IDLE;
         end else if (~cs_act) begin
            abort <= 1'b0;
         end
         // Words ignored during abort or user I/O
         if (!abort && !pins_user_io) begin
            if (word_in) begin
               case (state_q)
                  ST_IDLE: begin
                     if (din_q == `SYNC_WORD) begin
                        synced  <= 1'b1;
                        state_q <= ST_HDR;
                     end
                  end
                  ST_HDR: begin
                     if (din_q == `NO_OP_WORD) begin
                        if (flush_q != 2'h0)
                           flush_q <= flush_q - 2'h1;
                     end else if (htype == `HDR_TYPE1 &&
                                  hop == `HDR_OP_READ) begin
                        addr_q  <= din_q[17:`HDR_ADDR_LSB];
                        count_q <= {16'h0000,
                                    din_q[`HDR_CNT1_W-1:0]};
                        op_q    <= `HDR_OP_READ;
                        flush_q <= `FLUSH_WORDS;
                        state_q <= ST_RDATA;
                     end else if (htype == `HDR_TYPE1 &&
                                  hop == `HDR_OP_WRITE) begin
                        addr_q  <= din_q[17:`HDR_ADDR_LSB];
                        count_q <= {16'h0000,
                                    din_q[`HDR_CNT1_W-1:0]};
                        op_q    <= `HDR_OP_WRITE;
                        state_q <= ST_WDATA;
                     end else if (htype == `HDR_TYPE2) begin
                        count_q <= din_q[26:0];
                        state_q <= (op_q == `HDR_OP_READ) ?
                                   ST_RDATA : ST_WDATA;
                     end
                  end
                  ST_WDATA: begin
                     if (addr_q == `REG_CMD) begin
                        if (din_q == `DESYNCHRONIZE_CMD) begin
                           synced <= 1'b0;
                        end else if (din_q == `GLOBAL_CAPTURE_CMD) begin
                           capture_strobe    <= 1'b1;
                           capture_with_regs <= 1'b1;
                        end
                     end
                     if (count_q <= 27'h000_0001)
                        state_q <= (addr_q == `REG_CMD &&
                                    din_q == `DESYNCHRONIZE_CMD) ?
                                   ST_IDLE : ST_HDR;
                     count_q <= count_q - 27'h000_0001;
                  end
                  ST_RDATA: begin
                     // No-operation words flush before the read
                     if (flush_q != 2'h0 && din_q == `NO_OP_WORD)
                        flush_q <= flush_q - 2'h1;
                  end
                  default: state_q <= ST_IDLE;
               endcase
            end else if (word_out && state_q == ST_RDATA) begin
               // Unreadable registers read as zero
               if (readable(addr_q) && count_q != 27'h000_0000) begin
                  data_out <= reg_read(addr_q);
                  frame_word_pop <= (addr_q == `REG_FRAME_OUT);
               end else begin
                  data_out <= {DW{1'b0}};
               end
               if (count_q <= 27'h000_0001)
                  state_q <= ST_HDR;
               count_q <= count_q - 27'h000_0001;
            end
         end
         if (design_shutdown == 1'b0 && state_q == ST_IDLE)
            capture_with_regs <= capture_with_regs & ~rse[2] ?
                                 1'b0 : capture_with_regs;
      end
   end
endmodule // config_port_readback

// *** tb/cfg_host_model.sv ***
/* Host side of the parallel configuration port: word writes, reads
   and direction turns. Assumes clock is the 10 MHz system clock. */
`timescale 1ns/10ps
module cfg_host_model (
   input  wire        clock,
   output reg         config_clock,
   output reg         chip_select_n,
   output reg         read_write_select_n,
   output reg  [31:0] data_in
);
   initial begin
      config_clock = 1'b0;
      chip_select_n = 1'b1;
      read_write_select_n = 1'b0;
      data_in = 32'h0000_0000;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // One config clock period of 8 clocks, select held low
   task automatic pulse(input [31:0] w);
      data_in <= w;
      chip_select_n <= 1'b0;
      tick(1);
      config_clock <= 1'b1;
      tick(6);
      config_clock <= 1'b0;
      data_in <= ~w;
      tick(1);
   endtask
   task automatic write_word(input [31:0] w);
      pulse(w);
   endtask
   task automatic read_cycle();
      pulse(data_in);
   endtask
   task automatic turn(input dir);
      chip_select_n <= 1'b1;
      tick(2);
      read_write_select_n <= dir;
      tick(2);
   endtask
   task automatic bad_turn();
      chip_select_n <= 1'b0;
      tick(2);
      read_write_select_n <= ~read_write_select_n;
      tick(6);
   endtask
endmodule // cfg_host_model

// *** tb/config_port_readback_asserts.sv ***
/* Checker on the readback port pins and status outputs.
   Assumes the bind below onto config_port_readback. */
`timescale 1ns/10ps
module config_port_readback_asserts #(
   parameter DW = 32
) (
   input wire          clock,
   input wire          sys_rst,
   input wire          chip_select_n,
   input wire          read_write_select_n,
   input wire          persist,
   input wire          config_done,
   input wire [DW-1:0] data_out,
   input wire          data_oe,
   input wire          pins_user_io,
   input wire          capture_strobe,
   input wire          synced,
   input wire          abort
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_oe_write_dir: assert property ((!read_write_select_n) [*5] |-> !data_oe)
      else $error("data pins driven in write direction");
   a_oe_needs_cs: assert property (chip_select_n [*5] |-> !data_oe)
      else $error("data pins driven while deselected");
   a_user_io_quiet: assert property (pins_user_io |-> !data_oe)
      else $error("data pins driven while handed to user");
   a_user_io_set: assert property ((config_done && !persist) [*4] |-> pins_user_io)
      else $error("pins not returned to user after configuration");
   a_persist_keeps: assert property (persist [*4] |-> !pins_user_io)
      else $error("pins returned to user despite persist");
   a_abort_clear: assert property (chip_select_n [*5] |-> !abort)
      else $error("abort held while deselected");
   a_strobe_pulse: assert property (capture_strobe |=> !capture_strobe)
      else $error("capture strobe longer than one cycle");
   a_data_hold: assert property ((!read_write_select_n) [*6] |=> $stable(data_out))
      else $error("read word changed outside a read cycle");
   a_sync_taken: assert property ($rose(synced) |->
      $past(!chip_select_n, 3) && $past(!read_write_select_n, 3))
      else $error("sync taken without a selected write");
endmodule // config_port_readback_asserts
bind config_port_readback config_port_readback_asserts #(.DW(DW)) i_chk (
   .clock(clock), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
   .read_write_select_n(read_write_select_n), .persist(persist),
   .config_done(config_done), .data_out(data_out), .data_oe(data_oe),
   .pins_user_io(pins_user_io), .capture_strobe(capture_strobe),
   .synced(synced), .abort(abort));

// *** tb/tb.sv ***
/* Self-checking bench for config_port_readback with a host model.
   Assumes the design defines header on the include path. */
`timescale 1ns/10ps
`include "cfg_port_defines.vh"
module tb;
   reg         clock, sys_rst, persist, config_done;
   reg         design_shutdown, capture_trigger;
   reg  [31:0] status_word, cor0_word, idcode_word, frame_word;
   wire        cfg_clk, cs_n, rw_n, data_oe, pins_user_io, synced;
   wire        abort, capture_strobe, pop, cap_regs, deny;
   wire [31:0] din, data_out;
   integer     seed, bad_count, tests_run, i, pops;
   reg  [31:0] exp_q[$];
   reg  [31:0] hdr_tab[3] = '{32'h2800_E001, 32'h2801_2001, 32'h2801_8001};
   reg  [31:0] pre_tab[7] = '{32'hFFFF_FFFF, 32'h0000_00BB, 32'h1122_0044,
      32'hFFFF_FFFF, `SYNC_WORD, `NO_OP_WORD, `NO_OP_WORD};
   cfg_host_model i_host (.clock(clock), .config_clock(cfg_clk),
      .chip_select_n(cs_n), .read_write_select_n(rw_n), .data_in(din));
   config_port_readback i_dut (.clock(clock), .sys_rst(sys_rst),
      .config_clock(cfg_clk), .chip_select_n(cs_n), .read_write_select_n(rw_n),
      .data_in(din), .data_out(data_out), .data_oe(data_oe), .persist(persist),
      .config_done(config_done), .design_shutdown(design_shutdown),
      .status_word(status_word), .cor0_word(cor0_word), .idcode_word(idcode_word),
      .frame_word(frame_word), .capture_trigger(capture_trigger),
      .frame_word_pop(pop), .capture_strobe(capture_strobe),
      .capture_with_regs(cap_regs), .bram_user_deny(deny),
      .pins_user_io(pins_user_io), .synced(synced), .abort(abort));
   always @(posedge clock) if (pop === 1'b1) pops = pops + 1;
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic check(input string what, input [31:0] exp, input [31:0] got);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      if (bad_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic read_reg(input [31:0] hdr, input [31:0] exp);
      i_host.write_word(hdr);
      repeat (2) i_host.write_word(`NO_OP_WORD);
      check("bram_user_deny", hdr[17:13] == `REG_FRAME_OUT, deny);
      i_host.turn(1'b1);
      exp_q.push_back(exp);
      i_host.read_cycle();
      i_host.turn(1'b0);
   endtask
   // Read results compared at the fall of each read config clock
   always @(negedge cfg_clk) if (rw_n === 1'b1 && cs_n === 1'b0) begin
      check("data_oe", 1, data_oe);
      if (exp_q.size() == 0) check("read_unexpected", 0, 1);
      else check("data_out", exp_q.pop_front(), data_out);
   end
   initial begin
      seed = 32'h2726;
      bad_count = 0;
      tests_run = 0;
      pops = 0;
      sys_rst = 1'b1;
      {persist, config_done, design_shutdown, capture_trigger} = 4'h0;
      status_word = $random(seed);
      cor0_word = $random(seed);
      idcode_word = $random(seed);
      frame_word = $random(seed);
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clock);
      i_host.write_word(32'h2800_E001);
      check("synced", 0, synced);
      foreach (pre_tab[k]) i_host.write_word(pre_tab[k]);
      check("synced", 1, synced);
      check("data_oe", 0, data_oe);
      for (i = 0; i < 3; i++) begin
         design_shutdown <= $random(seed);
         read_reg(hdr_tab[i], i == 0 ? status_word : i == 1 ? cor0_word : idcode_word);
      end
      read_reg(32'h2800_6001, frame_word);
      check("frame_word_pop", 1, pops);
      i_host.write_word(32'h3000_8001);
      i_host.write_word(`GLOBAL_CAPTURE_CMD);
      check("capture_with_regs", 1, cap_regs);
      i_host.write_word(32'h3000_8001);
      i_host.write_word(`DESYNCHRONIZE_CMD);
      repeat (2) i_host.write_word(`NO_OP_WORD);
      check("synced", 0, synced);
      foreach (pre_tab[k]) i_host.write_word(pre_tab[k]);
      i_host.bad_turn();
      check("abort", 1, abort);
      i_host.turn(1'b0);
      check("abort", 0, abort);
      config_done <= 1'b1;
      repeat (5) @(posedge clock);
      check("pins_user_io", 1, pins_user_io);
      persist <= 1'b1;
      repeat (5) @(posedge clock);
      check("pins_user_io", 0, pins_user_io);
      capture_trigger <= 1'b1;
      for (i = 0; i < 10 && capture_strobe !== 1'b1; i++) @(negedge clock);
      check("capture_strobe", 1, capture_strobe);
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge clock);
      bad_count = bad_count + 1;
      stop_test();
   end
endmodule // tb
